//--- frmr_regs.sv
`timescale 1ns/1ps
module frmr_regs #(
  parameter logic [255:0] LEGAL_TYPES = frmr_pkg::LEGAL_TYPES_DEFAULT
) (
  // clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          srst_in,
  // register access
  input  wire frmr_pkg::frmr_req_t           req_in,
  output frmr_pkg::frmr_rsp_t                rsp_out,
  // type lookup
  input  wire logic [frmr_pkg::ADDR_W-1:0]   look_addr_in,
  output frmr_pkg::frmr_look_t               look_out
);

  // ****************************************
  // storage
  // ****************************************
  logic [frmr_pkg::NUM_REGS-1:0][frmr_pkg::NUM_FIELDS-1:0][frmr_pkg::FIELD_W-1:0] types;
  logic [frmr_pkg::NUM_REGS-1:0][frmr_pkg::NUM_FIELDS-1:0][frmr_pkg::FIELD_W-1:0] next_types;
  frmr_pkg::frmr_rsp_t  rsp;
  frmr_pkg::frmr_rsp_t  next_rsp;
  frmr_pkg::frmr_look_t look;
  frmr_pkg::frmr_look_t next_look;

  logic                              mapped;
  logic [1:0]                        sel;
  logic [frmr_pkg::NUM_FIELDS-1:0]   bad_field;
  logic                              bad_write;

  // ****************************************
  // index decode
  // ****************************************
  always_comb begin
    mapped = 1'b1;
    sel    = 2'(frmr_pkg::SEL_LOW);
    unique case (req_in.index)
      frmr_pkg::IDX_FIXED_16K_TYPES_LOW:  sel = 2'(frmr_pkg::SEL_LOW);
      frmr_pkg::IDX_FIXED_16K_TYPES_HIGH: sel = 2'(frmr_pkg::SEL_HIGH);
      frmr_pkg::IDX_FIXED_4K_TYPES_C0:    sel = 2'(frmr_pkg::SEL_4K);
      default:                            mapped = 1'b0;
    endcase
  end

  // ****************************************
  // type code check per field
  // ****************************************
  for (genvar f = 0; f < frmr_pkg::NUM_FIELDS; f++) begin : g_chk
    assign bad_field[f] =
      !LEGAL_TYPES[req_in.wdata[f*frmr_pkg::FIELD_W +: frmr_pkg::FIELD_W]];
  end
  assign bad_write = |bad_field;

  // ****************************************
  // register access
  // ****************************************
  always_comb begin
    next_types = types;
    next_rsp   = '0;
    if (req_in.valid) begin
      next_rsp.ack      = 1'b1;
      next_rsp.unmapped = !mapped;
      if (req_in.write) begin
        if (mapped && bad_write) begin
          next_rsp.gp_fault = 1'b1;
        end else if (mapped) begin
          next_types[sel] = req_in.wdata;
        end
      end else if (mapped) begin
        next_rsp.rdata = types[sel];
      end
    end
  end

  // fields keep no reset value
  always_ff @(posedge clock_in) begin
    types <= next_types;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end
  assign rsp_out = rsp;

  // ****************************************
  // range lookup
  // ****************************************
  always_comb begin
    next_look = '0;
    if (look_addr_in[19:18] == frmr_pkg::RANGE_16K_TOP) begin
      next_look.hit      = 1'b1;
      next_look.mem_type = types[look_addr_in[frmr_pkg::A16K_REG_BIT]]
        [look_addr_in[frmr_pkg::A16K_FLD_HI:frmr_pkg::A16K_FLD_LO]];
    end else if (look_addr_in[19:15] == frmr_pkg::RANGE_4K_TOP) begin
      next_look.hit      = 1'b1;
      next_look.mem_type = types[frmr_pkg::SEL_4K]
        [look_addr_in[frmr_pkg::A4K_FLD_HI:frmr_pkg::A4K_FLD_LO]];
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      look <= '0;
    end else begin
      look <= next_look;
    end
  end
  assign look_out = look;

  // ****************************************
  // checks
  // ****************************************
  AST_LOW_FIELD0: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'h80000 && look_addr_in <= 20'h83fff
    |=> look_out.hit && look_out.mem_type == $past(types[0][0]))
    else $error("80000h range does not read low register bits 7-0");

  AST_LOW_FIELD7: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'h9c000 && look_addr_in <= 20'h9ffff
    |=> look_out.hit && look_out.mem_type == $past(types[0][7]))
    else $error("9c000h range does not read low register bits 63-56");

  AST_HIGH_FIELD0: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'ha0000 && look_addr_in <= 20'ha3fff
    |=> look_out.hit && look_out.mem_type == $past(types[1][0]))
    else $error("a0000h range does not read high register bits 7-0");

  AST_HIGH_FIELD7: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'hbc000 && look_addr_in <= 20'hbffff
    |=> look_out.hit && look_out.mem_type == $past(types[1][7]))
    else $error("bc000h range does not read high register bits 63-56");

  AST_4K_FIELD0: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'hc0000 && look_addr_in <= 20'hc0fff
    |=> look_out.hit && look_out.mem_type == $past(types[2][0]))
    else $error("c0000h range does not read 4k register bits 7-0");

  AST_4K_FIELD7: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'hc7000 && look_addr_in <= 20'hc7fff
    |=> look_out.hit && look_out.mem_type == $past(types[2][7]))
    else $error("c7000h range does not read 4k register bits 63-56");

  AST_BAD_TYPE: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && req_in.write && mapped && bad_write
    |=> rsp_out.ack && rsp_out.gp_fault && types == $past(types))
    else $error("undefined type write not refused");

  AST_LOW_FIELD4: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'h90000 && look_addr_in <= 20'h93fff
    |=> look_out.mem_type == $past(types[0][4]))
    else $error("90000h range does not read low register bits 39-32");

  AST_LOW_FIELD1: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'h84000 && look_addr_in <= 20'h87fff
    |=> look_out.hit && look_out.mem_type == $past(types[0][1]))
    else $error("84000h range does not read low register bits 15-8");

  AST_4K_FIELD1: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in >= 20'hc1000 && look_addr_in <= 20'hc1fff
    |=> look_out.hit && look_out.mem_type == $past(types[2][1]))
    else $error("c1000h range does not read 4k register bits 15-8");

  AST_OUT_OF_RANGE: assert property (@(posedge clock_in) disable iff (srst_in)
    look_addr_in < 20'h80000 || look_addr_in > 20'hc7fff
    |=> look_out == '0)
    else $error("address outside the fixed ranges reported a hit");

  AST_LOW_WRITE: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && req_in.write && mapped && !bad_write
      && req_in.index == frmr_pkg::IDX_FIXED_16K_TYPES_LOW
    |=> types[frmr_pkg::SEL_LOW] == $past(req_in.wdata))
    else $error("legal write did not land in the low 16k register");

  AST_HIGH_WRITE: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && req_in.write && mapped && !bad_write
      && req_in.index == frmr_pkg::IDX_FIXED_16K_TYPES_HIGH
    |=> types[frmr_pkg::SEL_HIGH] == $past(req_in.wdata))
    else $error("legal write did not land in the high 16k register");

  AST_4K_WRITE: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && req_in.write && mapped && !bad_write
      && req_in.index == frmr_pkg::IDX_FIXED_4K_TYPES_C0
    |=> types[frmr_pkg::SEL_4K] == $past(req_in.wdata))
    else $error("legal write did not land in the 4k register");

  AST_GOOD_WRITE: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && req_in.write && mapped && !bad_write
    |=> rsp_out.ack && !rsp_out.gp_fault)
    else $error("legal write was refused");

  AST_READ_BACK: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && !req_in.write && mapped
    |=> rsp_out.ack && rsp_out.rdata == $past(types[sel]))
    else $error("read did not return the stored fields");

  AST_UNMAPPED: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid && !mapped
    |=> rsp_out.unmapped && !rsp_out.gp_fault && rsp_out.rdata == '0
        && types == $past(types))
    else $error("unmapped access was not answered quietly");

  AST_ACK_PULSE: assert property (@(posedge clock_in) disable iff (srst_in)
    req_in.valid
    |=> rsp_out.ack)
    else $error("request was not acknowledged one cycle later");

  AST_NO_STRAY_ACK: assert property (@(posedge clock_in) disable iff (srst_in)
    !req_in.valid
    |=> rsp_out == '0)
    else $error("response raised without a request");

  AST_RESET_QUIET: assert property (@(posedge clock_in)
    srst_in
    |=> rsp_out == '0 && look_out == '0)
    else $error("outputs not cleared by reset");

endmodule

//--- frmr_pkg.sv
package frmr_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [31:0] IDX_FIXED_16K_TYPES_LOW  = 32'h0000_0258;
  localparam logic [31:0] IDX_FIXED_16K_TYPES_HIGH = 32'h0000_0259;
  localparam logic [31:0] IDX_FIXED_4K_TYPES_C0    = 32'h0000_0268;

  // ****************************************
  // layout
  // ****************************************
  localparam int NUM_REGS    = 3;
  localparam int NUM_FIELDS  = 8;
  localparam int FIELD_W     = 8;
  localparam int REG_W       = 64;
  localparam int ADDR_W      = 20;
  localparam int SEL_LOW     = 0;
  localparam int SEL_HIGH    = 1;
  localparam int SEL_4K      = 2;

  // ****************************************
  // address decode of the fixed ranges
  // ****************************************
  localparam logic [1:0] RANGE_16K_TOP = 2'h2;   // addr[19:18] for 80000h..bffffh
  localparam logic [4:0] RANGE_4K_TOP  = 5'h18;  // addr[19:15] for c0000h..c7fffh
  localparam int A16K_REG_BIT = 17;
  localparam int A16K_FLD_HI  = 16;
  localparam int A16K_FLD_LO  = 14;
  localparam int A4K_FLD_HI   = 14;
  localparam int A4K_FLD_LO   = 12;

  // ****************************************
  // default set of legal type codes (one bit per code)
  // ****************************************
  localparam logic [255:0] LEGAL_TYPES_DEFAULT = 256'h73;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic             valid;
    logic             write;
    logic [31:0]      index;
    logic [REG_W-1:0] wdata;
  } frmr_req_t;

  typedef struct packed {
    logic             ack;
    logic             gp_fault;
    logic             unmapped;
    logic [REG_W-1:0] rdata;
  } frmr_rsp_t;

  typedef struct packed {
    logic               hit;
    logic [FIELD_W-1:0] mem_type;
  } frmr_look_t;

endpackage

//--- frmr_regs_test.sv
`timescale 1ns/1ps
module frmr_regs_test;
  // ****************************************
  // bench
  // ****************************************
  logic                 clock_in;
  logic                 srst_in;
  frmr_pkg::frmr_req_t  req_in;
  frmr_pkg::frmr_rsp_t  rsp_out;
  logic [19:0]          look_addr_in;
  frmr_pkg::frmr_look_t look_out;
  int                   error_cnt;
  int                   num_checks;

  frmr_regs frmr_regs_inst (.clock_in(clock_in), .srst_in(srst_in), .req_in(req_in),
    .rsp_out(rsp_out), .look_addr_in(look_addr_in), .look_out(look_out));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one access, answer checked while it stands, then one quiet edge
  task automatic access(input logic wr, input logic [31:0] idx, input logic [63:0] wd,
                        input logic gp, input logic um, input logic [63:0] rd_exp);
    req_in = '{valid: 1'b1, write: wr, index: idx, wdata: wd};
    @(posedge clock_in) #1;
    req_in.valid = 1'b0;
    check("ack", 64'(rsp_out.ack), 64'h1);
    check("gp_fault", 64'(rsp_out.gp_fault), 64'(gp));
    check("unmapped", 64'(rsp_out.unmapped), 64'(um));
    check("rdata", rsp_out.rdata, rd_exp);
    @(posedge clock_in) #1;
    check("ack_pulse", 64'(rsp_out.ack), 64'h0);
  endtask

  task automatic rd(input logic [31:0] idx, input logic [63:0] exp);
    access(1'b0, idx, 64'h0, 1'b0, 1'b0, exp);
  endtask

  task automatic look(input logic [19:0] a, input logic h, input logic [7:0] t);
    look_addr_in = a;
    @(posedge clock_in) #1;
    check("look_hit", 64'(look_out.hit), 64'(h));
    check("look_type", 64'(look_out.mem_type), 64'(t));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // words hold only legal type codes, except the two refused ones
  localparam logic [63:0] LOW_WORD   = 64'h0605_0401_0006_0504;
  localparam logic [63:0] HIGH_WORD  = 64'h0501_0405_0600_0104;
  localparam logic [63:0] C0_WORD    = 64'h0106_0504_0100_0605;
  localparam logic [63:0] BAD_WORD_A = 64'h0106_0504_0200_0605;
  localparam logic [63:0] BAD_WORD_B = 64'h0706_0504_0100_0605;

  task automatic scn_low();
    access(1'b1, frmr_pkg::IDX_FIXED_16K_TYPES_LOW, LOW_WORD, 1'b0, 1'b0, 64'h0);
    look(20'h80000, 1'b1, 8'h04);
    look(20'h84000, 1'b1, 8'h05);
    look(20'h90000, 1'b1, 8'h01);
    look(20'h9c000, 1'b1, 8'h06);
    look(20'h9ffff, 1'b1, 8'h06);
  endtask

  task automatic scn_high();
    access(1'b1, frmr_pkg::IDX_FIXED_16K_TYPES_HIGH, HIGH_WORD, 1'b0, 1'b0, 64'h0);
    look(20'ha0000, 1'b1, 8'h04);
    look(20'ha4000, 1'b1, 8'h01);
    look(20'hbc000, 1'b1, 8'h05);
    rd(frmr_pkg::IDX_FIXED_16K_TYPES_HIGH, HIGH_WORD);
  endtask

  task automatic scn_4k();
    access(1'b1, frmr_pkg::IDX_FIXED_4K_TYPES_C0, C0_WORD, 1'b0, 1'b0, 64'h0);
    look(20'hc0fff, 1'b1, 8'h05);
    look(20'hc1000, 1'b1, 8'h06);
    look(20'hc7000, 1'b1, 8'h01);
    rd(frmr_pkg::IDX_FIXED_4K_TYPES_C0, C0_WORD);
  endtask

  task automatic scn_fault();
    access(1'b1, frmr_pkg::IDX_FIXED_4K_TYPES_C0, BAD_WORD_A, 1'b1, 1'b0, 64'h0);
    access(1'b1, frmr_pkg::IDX_FIXED_4K_TYPES_C0, BAD_WORD_B, 1'b1, 1'b0, 64'h0);
    rd(frmr_pkg::IDX_FIXED_4K_TYPES_C0, C0_WORD);
    look(20'hc7fff, 1'b1, 8'h01);
  endtask

  task automatic scn_edges();
    access(1'b1, 32'h0000_025a, 64'hffff_ffff_ffff_ffff, 1'b0, 1'b1, 64'h0);
    access(1'b0, 32'h0000_025a, 64'h0, 1'b0, 1'b1, 64'h0);
    rd(frmr_pkg::IDX_FIXED_16K_TYPES_LOW, LOW_WORD);
    look(20'h7ffff, 1'b0, 8'h00);
    look(20'hc8000, 1'b0, 8'h00);
  endtask

  // mid-run reset clears the outputs but not the stored fields
  task automatic scn_reset();
    look_addr_in = 20'h80000;
    srst_in = 1'b1;
    @(posedge clock_in) #1;
    check("look_hit_reset", 64'(look_out.hit), 64'h0);
    srst_in = 1'b0;
    @(posedge clock_in) #1;
    check("look_hit_after", 64'(look_out.hit), 64'h1);
    check("look_type_after", 64'(look_out.mem_type), 64'h04);
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    srst_in = 1'b1;
    req_in = '0;
    look_addr_in = 20'h0;
    repeat (16) @(posedge clock_in);
    #1;
    srst_in = 1'b0;
    check("ack_reset", 64'(rsp_out.ack), 64'h0);
    scn_low();
    scn_high();
    scn_4k();
    scn_fault();
    scn_edges();
    scn_reset();
    conclude();
  end
endmodule
